// ---- qdma_pkg.sv ----
// Contract
// (RULE_01) Host may correct codes: raw - off - (fs - off) * (raw - 1024) / 64512.
// (RULE_02) Host should measure offset at code 1024 and gain at 64512.
// (RULE_03) Host may measure full scale at 32768; division becomes a 15-bit shift.
// (RULE_04) Sixteen devices share one bus for 64 synchronously updated channels.
// (RULE_05) Temporary registers load one by one; one broadcast transfers all to outputs.
// (RULE_06) One broadcast command writes the same data or power-down to every channel.
// (RULE_07) Output updates happen at the falling clock edge ending the last acknowledge.
// (RULE_08) Bus address uses the two low pins; high pins decode locally.
// (RULE_09) Devices sharing a bus address all acknowledge the address byte together; this one withholds it while its record buffer is full.
// (RULE_10) Act only when the top two control bits equal the high pins.
// (RULE_11) Device index minus one equals the four pins, high pin first.
// (RULE_12) Two channel-select bits pick a channel, forming a six-bit channel address.
// (RULE_13) Broadcast bus address 10010000 is accepted whatever the low pins.
// (RULE_14) Broadcast command bits both one: act whatever high pins, select all channels.
// (RULE_15) System fixes pins at power-up; controller matches address and control bits.
// (RULE_16) With all pins and load pin low, address byte 1001 1000 is acknowledged.
// (RULE_17) Frame is start, address, control, high, low, stop; each byte acknowledged.
// (RULE_18) High and low data bytes form one 16-bit code, high byte first.
// (RULE_19) Without local match or broadcast, registers and outputs stay unchanged.
package qdma_pkg;

    localparam int          QDMA_CHANNELS   = 4;
    localparam int          QDMA_CODE_W     = 16;
    localparam int          QDMA_FIFO_DEPTH = 16;
    localparam int          QDMA_WORD_W     = QDMA_CODE_W + 1;
    localparam int          QDMA_UPD_W      = 2 + QDMA_CHANNELS + QDMA_WORD_W;
    localparam int          QDMA_SYNC_W     = 7;

    // Bus address fields
    localparam logic [4:0]  QDMA_ADDR_FIXED = 5'h13;
    localparam logic [6:0]  QDMA_ADDR_BCAST = 7'h48;
    localparam logic [3:0]  QDMA_BYTE_BITS  = 4'h8;

    // Control byte field positions
    localparam int          QDMA_C_SEL_HI   = 7;
    localparam int          QDMA_C_SEL_LO   = 6;
    localparam int          QDMA_C_MODE_HI  = 5;
    localparam int          QDMA_C_MODE_LO  = 4;
    localparam int          QDMA_C_STORED   = 3;
    localparam int          QDMA_C_CHAN_HI  = 2;
    localparam int          QDMA_C_CHAN_LO  = 1;
    localparam int          QDMA_C_PD       = 0;

    // Load modes
    localparam logic [1:0]  QDMA_LD_STORE   = 2'h0;
    localparam logic [1:0]  QDMA_LD_SINGLE  = 2'h1;
    localparam logic [1:0]  QDMA_LD_ALL     = 2'h2;
    localparam logic [1:0]  QDMA_LD_BCAST   = 2'h3;

    localparam logic [QDMA_WORD_W-1:0] QDMA_WORD_RST = 17'h00000;

    typedef enum logic [3:0] {
        QDMA_ST_IDLE     = 4'h0,
        QDMA_ST_ADDR     = 4'h1,
        QDMA_ST_ADDR_ACK = 4'h3,
        QDMA_ST_CTRL     = 4'h2,
        QDMA_ST_CTRL_ACK = 4'h6,
        QDMA_ST_MSB      = 4'h7,
        QDMA_ST_MSB_ACK  = 4'h5,
        QDMA_ST_LSB      = 4'h4,
        QDMA_ST_LSB_ACK  = 4'hc,
        QDMA_ST_IGNORE   = 4'hd
    } qdma_state_t;

endpackage

// ---- qdma_sync.sv ----
`timescale 1ns/1ps
module qdma_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } qdma_sync_t;

    qdma_sync_t s_q;
    qdma_sync_t s_d;

    // First stage feeds only the second
    always_comb begin
        s_d      = s_q;
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;

endmodule

// ---- qdma_fifo.sv ----
`timescale 1ns/1ps
module qdma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } qdma_fifo_t;

    qdma_fifo_t s_q;
    qdma_fifo_t s_d;
    logic       do_wr;
    logic       do_rd;

    assign in_ready  = (s_q.cnt != FULL);
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rd];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (do_wr) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = (s_q.wr == LAST) ? '0 : s_q.wr + PW'(1);
        end
        if (do_rd) begin
            s_d.rd = (s_q.rd == LAST) ? '0 : s_q.rd + PW'(1);
        end
        // Count tracks both sides so full and empty stay exact
        s_d.cnt = s_q.cnt + CW'(do_wr) - CW'(do_rd);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ---- qdma_top.sv ----
`timescale 1ns/1ps
module qdma_top import qdma_pkg::*; #(
    parameter int FIFO_DEPTH = QDMA_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst,
    // Two-wire bus
    input  wire logic                                    scl,
    input  wire logic                                    sda_i,
    output logic                                         sda_o,
    output logic                                         sda_oe_n,
    // Address straps and load pin
    input  wire logic                                    addr_pin_low,
    input  wire logic                                    addr_pin_second,
    input  wire logic                                    local_addr_pin_low,
    input  wire logic                                    local_addr_pin_high,
    input  wire logic                                    load_outputs_pin,
    // Channel outputs
    output logic      [QDMA_CHANNELS-1:0][QDMA_CODE_W-1:0] chan_code,
    output logic      [QDMA_CHANNELS-1:0]                  chan_pd,
    // Update record stream
    output logic                                         upd_valid,
    input  wire logic                                    upd_ready,
    output logic      [QDMA_UPD_W-1:0]                   upd_data,
    // Status
    output logic                                         busy
);

    typedef struct packed {
        qdma_state_t                              st;
        logic [3:0]                               cnt;
        logic [7:0]                               shreg;
        logic [7:0]                               ctrl;
        logic [7:0]                               msb;
        logic                                     scl_prev;
        logic                                     sda_prev;
        logic                                     load_outputs_pin_prev;
        logic                                     sda_oe_n;
        logic [QDMA_CHANNELS-1:0][QDMA_WORD_W-1:0] temp;
        logic [QDMA_CHANNELS-1:0][QDMA_WORD_W-1:0] outv;
        logic                                     push;
        logic [QDMA_UPD_W-1:0]                    push_data;
    } qdma_core_t;

    qdma_core_t             s_q;
    qdma_core_t             s_d;
    logic [QDMA_SYNC_W-1:0] pins_s;
    logic                   scl_s;
    logic                   sda_s;
    logic                   a0_s;
    logic                   a1_s;
    logic                   a2_s;
    logic                   a3_s;
    logic                   load_outputs_pin_s;
    logic                   fifo_in_ready;

    // Bus lines idle high, so their stages reset high to avoid a false start
    qdma_sync #(
        .WIDTH   (QDMA_SYNC_W),
        .RST_VAL (7'h60)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .d       ({scl, sda_i, load_outputs_pin, local_addr_pin_high,
                   local_addr_pin_low, addr_pin_second, addr_pin_low}),
        .q       (pins_s)
    );

    assign scl_s  = pins_s[6];
    assign sda_s  = pins_s[5];
    assign load_outputs_pin_s = pins_s[4];
    assign a3_s   = pins_s[3];
    assign a2_s   = pins_s[2];
    assign a1_s   = pins_s[1];
    assign a0_s   = pins_s[0];

    // Decoded fields of the held control byte, and the address byte match
    logic       bcast_cmd;
    logic       local_hit;
    logic       selected;
    logic [1:0] mode;
    logic [1:0] chan;
    logic       addr_hit;

    assign mode      = {s_q.ctrl[QDMA_C_MODE_HI], s_q.ctrl[QDMA_C_MODE_LO]};
    assign chan      = {s_q.ctrl[QDMA_C_CHAN_HI], s_q.ctrl[QDMA_C_CHAN_LO]};
    assign bcast_cmd = (mode == QDMA_LD_BCAST); // RULE_14
    // High pins compared against the top control bits
    assign local_hit = ({s_q.ctrl[QDMA_C_SEL_HI], s_q.ctrl[QDMA_C_SEL_LO]}
                        == {a3_s, a2_s}); // RULE_10 RULE_11 RULE_04
    assign selected  = bcast_cmd || local_hit; // RULE_19
    // Only the low pins enter the bus address; write direction only
    assign addr_hit  = (s_q.shreg[0] == 1'b0) &&
                       ((s_q.shreg[7:1] == {QDMA_ADDR_FIXED, a1_s, a0_s}) || // RULE_08 RULE_16
                        (s_q.shreg[7:1] == QDMA_ADDR_BCAST)); // RULE_13

    always_comb begin
        logic                                      scl_rise;
        logic                                      scl_fall;
        logic                                      start;
        logic                                      stop;
        logic                                      shifting;
        logic [QDMA_CHANNELS-1:0]                  mask;
        logic [QDMA_WORD_W-1:0]                    word;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start    = 1'b0;
        stop     = 1'b0;
        shifting = 1'b0;
        mask     = '0;
        word     = '0;

        s_d           = s_q;
        s_d.scl_prev  = scl_s;
        s_d.sda_prev  = sda_s;
        s_d.load_outputs_pin_prev = load_outputs_pin_s;
        s_d.push      = 1'b0;

        scl_rise = !s_q.scl_prev && scl_s;
        scl_fall = s_q.scl_prev && !scl_s;
        start    = s_q.scl_prev && scl_s && s_q.sda_prev && !sda_s;
        stop     = s_q.scl_prev && scl_s && !s_q.sda_prev && sda_s;
        shifting = (s_q.st == QDMA_ST_ADDR) || (s_q.st == QDMA_ST_CTRL) ||
                   (s_q.st == QDMA_ST_MSB) || (s_q.st == QDMA_ST_LSB);

        // Load pin edge moves every stored word to its output
        if (load_outputs_pin_s && !s_q.load_outputs_pin_prev) begin
            s_d.outv = s_q.temp;
        end

        // Frame-ending 16-bit code, high byte first
        word = {s_q.ctrl[QDMA_C_PD], s_q.msb, s_q.shreg}; // RULE_18
        mask = bcast_cmd ? {QDMA_CHANNELS{1'b1}} // RULE_14
                         : QDMA_CHANNELS'(1) << chan; // RULE_12

        if (start) begin
            s_d.st       = QDMA_ST_ADDR;
            s_d.cnt      = '0;
            s_d.sda_oe_n = 1'b1;
        end else if (stop) begin
            s_d.st       = QDMA_ST_IDLE;
            s_d.sda_oe_n = 1'b1;
        end else if (scl_rise && shifting) begin
            s_d.shreg = {s_q.shreg[6:0], sda_s};
            s_d.cnt   = s_q.cnt + 4'h1;
        end else if (scl_fall) begin
            unique case (s_q.st)
                QDMA_ST_IDLE, QDMA_ST_IGNORE: begin
                    s_d.sda_oe_n = 1'b1;
                end
                QDMA_ST_ADDR: begin
                    if (s_q.cnt == QDMA_BYTE_BITS) begin
                        s_d.cnt = '0;
                        // A full record buffer refuses the frame at its address
                        if (addr_hit && fifo_in_ready) begin
                            s_d.st       = QDMA_ST_ADDR_ACK;
                            s_d.sda_oe_n = 1'b0; // RULE_09 RULE_17
                        end else begin
                            s_d.st = QDMA_ST_IGNORE;
                        end
                    end
                end
                QDMA_ST_ADDR_ACK: begin
                    s_d.st       = QDMA_ST_CTRL;
                    s_d.sda_oe_n = 1'b1;
                end
                QDMA_ST_CTRL: begin
                    if (s_q.cnt == QDMA_BYTE_BITS) begin
                        s_d.cnt      = '0;
                        s_d.ctrl     = s_q.shreg;
                        s_d.st       = QDMA_ST_CTRL_ACK;
                        s_d.sda_oe_n = 1'b0; // RULE_17
                    end
                end
                QDMA_ST_CTRL_ACK: begin
                    s_d.st       = QDMA_ST_MSB;
                    s_d.sda_oe_n = 1'b1;
                end
                QDMA_ST_MSB: begin
                    if (s_q.cnt == QDMA_BYTE_BITS) begin
                        s_d.cnt      = '0;
                        s_d.msb      = s_q.shreg;
                        s_d.st       = QDMA_ST_MSB_ACK;
                        s_d.sda_oe_n = 1'b0; // RULE_17
                    end
                end
                QDMA_ST_MSB_ACK: begin
                    s_d.st       = QDMA_ST_LSB;
                    s_d.sda_oe_n = 1'b1;
                end
                QDMA_ST_LSB: begin
                    if (s_q.cnt == QDMA_BYTE_BITS) begin
                        s_d.cnt      = '0;
                        s_d.st       = QDMA_ST_LSB_ACK;
                        s_d.sda_oe_n = 1'b0; // RULE_17
                    end
                end
                QDMA_ST_LSB_ACK: begin
                    // Old outputs hold until this edge
                    s_d.st       = QDMA_ST_IGNORE;
                    s_d.sda_oe_n = 1'b1;
                    if (selected) begin // RULE_19
                        s_d.push      = 1'b1; // RULE_07
                        s_d.push_data = {mode, mask, word};
                        unique case (mode)
                            QDMA_LD_STORE: begin
                                for (int i = 0; i < QDMA_CHANNELS; i++) begin
                                    if (mask[i]) begin
                                        s_d.temp[i] = word; // RULE_05
                                    end
                                end
                            end
                            QDMA_LD_SINGLE: begin
                                for (int i = 0; i < QDMA_CHANNELS; i++) begin
                                    if (mask[i]) begin
                                        s_d.temp[i] = word;
                                        s_d.outv[i] = word; // RULE_07
                                    end
                                end
                            end
                            QDMA_LD_ALL: begin
                                for (int i = 0; i < QDMA_CHANNELS; i++) begin
                                    if (mask[i]) begin
                                        s_d.temp[i] = word;
                                    end
                                end
                                s_d.outv = s_d.temp; // RULE_05
                            end
                            QDMA_LD_BCAST: begin
                                if (s_q.ctrl[QDMA_C_STORED]) begin
                                    s_d.outv = s_q.temp; // RULE_05 RULE_04
                                end else begin
                                    for (int i = 0; i < QDMA_CHANNELS; i++) begin
                                        s_d.temp[i] = word; // RULE_06
                                        s_d.outv[i] = word;
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    s_d.st       = QDMA_ST_IGNORE;
                    s_d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q           <= '0;
            s_q.st        <= QDMA_ST_IDLE;
            s_q.scl_prev  <= 1'b1;
            s_q.sda_prev  <= 1'b1;
            s_q.sda_oe_n  <= 1'b1;
            s_q.temp      <= {QDMA_CHANNELS{QDMA_WORD_RST}};
            s_q.outv      <= {QDMA_CHANNELS{QDMA_WORD_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    // Update records for the system side; slow draining gets new frames refused at their address
    qdma_fifo #(
        .WIDTH (QDMA_UPD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (s_q.push),
        .in_ready  (fifo_in_ready),
        .in_data   (s_q.push_data),
        .out_valid (upd_valid),
        .out_ready (upd_ready),
        .out_data  (upd_data)
    );

    // Never stretches the clock; only pulls data low
    assign sda_o    = 1'b0;
    assign sda_oe_n = s_q.sda_oe_n;
    assign busy     = (s_q.st != QDMA_ST_IDLE);

    always_comb begin
        for (int i = 0; i < QDMA_CHANNELS; i++) begin
            chan_code[i] = s_q.outv[i][QDMA_CODE_W-1:0];
            chan_pd[i]   = s_q.outv[i][QDMA_CODE_W];
        end
    end

endmodule

// ---- qdma_top_sva.sv ----
`timescale 1ns/1ps
module qdma_top_sva import qdma_pkg::*; (
    // Clock and reset
    input wire logic                                    ref_clk,
    input wire logic                                    rst,
    // Bus
    input wire logic                                    scl,
    input wire logic                                    sda_i,
    input wire logic                                    sda_oe_n,
    // Outputs and stream
    input wire logic [QDMA_CHANNELS-1:0][QDMA_CODE_W-1:0] chan_code,
    input wire logic [QDMA_CHANNELS-1:0]                  chan_pd,
    input wire logic                                    upd_valid,
    input wire logic                                    upd_ready,
    input wire logic [QDMA_UPD_W-1:0]                   upd_data,
    input wire logic                                    busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_ack_scl_low:
        assert property ($changed(sda_oe_n) |-> !scl)
        else $error("ack edge while bus clock high");
    a_ack_stands:
        assert property ($fell(sda_oe_n) |-> !sda_oe_n [*7])
        else $error("ack released too early");
    a_ack_in_frame:
        assert property (!sda_oe_n |-> busy)
        else $error("data line pulled outside a frame");
    a_update_edge:
        assert property ($changed(chan_code) |-> !scl || !busy)
        else $error("output code moved while bus clock high");
    a_pd_edge:
        assert property ($changed(chan_pd) |-> !scl || !busy)
        else $error("power-down flag moved while bus clock high");
    a_update_record:
        assert property ($changed(chan_code) && busy |=> upd_valid)
        else $error("frame update without record");
    a_record_hold:
        assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd_data))
        else $error("stalled record changed");
    a_start_busy:
        assert property ($fell(sda_i) && scl |-> ##[2:6] busy)
        else $error("start not taken");
    a_stop_idle:
        assert property ($rose(sda_i) && scl |-> ##[2:6] !busy)
        else $error("stop not taken");

    c_ack: cover property ($fell(sda_oe_n));
    c_stall: cover property (upd_valid && !upd_ready);
    c_pd: cover property ($changed(chan_pd));
endmodule

bind qdma_top qdma_top_sva u_sva (.ref_clk, .rst, .scl, .sda_i, .sda_oe_n, .chan_code,
    .chan_pd, .upd_valid, .upd_ready, .upd_data, .busy);

// ---- qdma_host_model.sv ----
`timescale 1ns/1ps
module qdma_host_model (
    // Clock
    input wire logic ref_clk,
    // Bus lines
    output logic     scl,
    output logic     sda_drv,
    input wire logic sda_line
);
    // Bus clock stands high between frames, never free running
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Offset and full-scale errors in LSBs; shift form avoids a divider
    function automatic logic [15:0] correct(input int raw, input int off, input int fs,
                                            input bit by_shift);
        int slope;
        slope = (fs - off) * (raw - 1024);
        if (by_shift) begin
            return 16'(raw - off - (slope >>> 15));
        end else begin
            return 16'(raw - off - slope / 64512);
        end
    endfunction

    // Data moves only while scl low; ack sampled mid high phase
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tick(1);
            sda_drv = b[i];
            tick(3);
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
        end
        tick(1);
        sda_drv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(2);
        ack = !sda_line;
        tick(2);
        scl = 1'b0;
    endtask

    // Whole frame always sent, so refused bytes are still clocked
    task automatic frame(input logic [31:0] f, output logic [3:0] acks);
        tick(1);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
        for (int k = 3; k >= 0; k--) begin
            put_byte(f[8*k+:8], acks[k]);
        end
        tick(1);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(8);
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top import qdma_pkg::*; ;
    // Clock, reset, bus
    logic                                    ref_clk, rst, scl, sda_drv, sda_i, sda_o, sda_oe_n;
    // Straps and load pin
    logic                                    addr_pin_low, addr_pin_second, load_outputs_pin;
    logic                                    local_addr_pin_low, local_addr_pin_high;
    // Outputs and stream
    logic [QDMA_CHANNELS-1:0][QDMA_CODE_W-1:0] chan_code;
    logic [QDMA_CHANNELS-1:0]                  chan_pd;
    logic                                    upd_valid, upd_ready, busy;
    logic [QDMA_UPD_W-1:0]                   upd_data;
    logic [3:0]                              p;
    int                                      miscompares = 0;
    int                                      checks_done = 0;

    // Open drain: either party pulls low, pull-up otherwise
    assign sda_i = sda_drv & (sda_oe_n | sda_o);

    // Small depth so the refusal is reached quickly
    qdma_top #(.FIFO_DEPTH(2)) u_dut (.ref_clk, .rst, .scl, .sda_i, .sda_o, .sda_oe_n,
        .addr_pin_low, .addr_pin_second, .local_addr_pin_low, .local_addr_pin_high,
        .load_outputs_pin, .chan_code, .chan_pd, .upd_valid, .upd_ready, .upd_data, .busy);
    qdma_host_model u_host (.ref_clk, .scl, .sda_drv, .sda_line(sda_i));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [31:0] f, input logic [3:0] exp_ack);
        logic [3:0] a;
        u_host.frame(f, a);
        chk(64'(a), 64'(exp_ack));
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        upd_ready = 1'b0;
        load_outputs_pin = 1'b0;
        p = 4'h0;
        {local_addr_pin_high, local_addr_pin_low, addr_pin_second, addr_pin_low} = p;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        u_host.tick(4);
        // Stream stalled: third frame must be refused
        send(32'h98104000, 4'hf);
        chk(64'(chan_code[0]), 64'h4000);
        chk(64'({upd_valid, upd_data}), 64'({1'b1, QDMA_LD_SINGLE, 4'h1, 1'b0, 16'h4000}));
        send(32'h9814c000, 4'hf);
        chk(64'(chan_code[2]), 64'hc000);
        send(32'h98120005, 4'h0);
        chk(64'(chan_code[1]), 64'h0);
        upd_ready = 1'b1;
        u_host.tick(4);
        chk(64'(upd_valid), 64'h0);
        // Store then update all
        send(32'h9800ffff, 4'hf);
        send(32'h98021234, 4'hf);
        chk(64'(chan_code[0]), 64'h4000);
        send(32'h98265678, 4'hf);
        chk(64'(chan_code), 64'h5678c0001234ffff);
        // Every device index, with foreign local and bus addresses
        for (int n = 0; n < 16; n++) begin
            p = n[3:0];
            {local_addr_pin_high, local_addr_pin_low, addr_pin_second, addr_pin_low} = p;
            u_host.tick(4);
            send({5'h13, p[1:0], 1'b0, p[3:2], 3'h2, p[1:0], 1'b0, 12'ha00, p}, 4'hf);
            chk(64'(chan_code[p[1:0]]), 64'({12'ha00, p}));
            send({5'h13, p[1:0], 1'b0, ~p[3:2], 3'h2, p[1:0], 1'b0, 16'hdead}, 4'hf);
            chk(64'(chan_code[p[1:0]]), 64'({12'ha00, p}));
            send({5'h13, ~p[1:0], 1'b0, p[3:2], 3'h2, p[1:0], 1'b0, 16'hdead}, 4'h0);
            chk(64'(chan_code[p[1:0]]), 64'({12'ha00, p}));
        end
        // Broadcast address and command, pins all high
        send(32'h90f00abc, 4'hf);
        chk(64'(chan_code), {4{16'h0abc}});
        send(32'h90f10000, 4'hf);
        chk(64'(chan_pd), 64'hf);
        send(32'h9ec21111, 4'hf);
        chk(64'(chan_code[1]), 64'h0);
        send(32'h90380000, 4'hf);
        chk(64'(chan_code), 64'h0000000011110000);
        // Load pin moves stored codes without a frame
        send(32'h9ec42222, 4'hf);
        load_outputs_pin = 1'b1;
        u_host.tick(8);
        chk(64'(chan_code[2]), 64'h2222);
        load_outputs_pin = 1'b0;
        u_host.tick(8);
        // Host-corrected codes to the last channel, offset 4 LSB
        send({16'h9ed6, u_host.correct(33792, 4, 130, 1'b0)}, 4'hf);
        chk(64'(chan_code[3]), 64'h83bc);
        send({16'h9ed6, u_host.correct(33792, 4, 132, 1'b1)}, 4'hf);
        chk(64'(chan_code[3]), 64'h837c);
        finish_test();
    end

    // Roughly 60 frames of about 310 cycles each
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end
endmodule
